// *** common/rdf_consts.vh ***
// rdf_consts.vh: offsets, field positions, reset values for the discharge/fault register bank
// assumes: included by bare name from design files; definitions only
`ifndef RDF_CONSTS_VH
`define RDF_CONSTS_VH

// register byte offsets (one aligned 32-bit word each)
`define RDF_OFF_DISCHARGE 4'h0
`define RDF_OFF_FAULT 4'h4
`define RDF_OFF_IRQ_MASK 4'h8
`define RDF_OFF_LIVE 4'hc
`define RDF_ADDR_W 4

// discharge-control fields
`define RDF_DIS_R1_LO 0
`define RDF_DIS_R2_LO 2
`define RDF_DIS_R3_LO 4
`define RDF_DIS_PASS_BIT 6
`define RDF_DIS_RESET 8'h00
`define RDF_DIS_MASK 8'h7f

// fault-status fields
`define RDF_FLT_SD5_BIT 4
`define RDF_FLT_SD6_BIT 5
`define RDF_FLT_RESET 8'h00
`define RDF_MASK_RESET 8'h00

// discharge strength codes
`define RDF_DIS_OFF 2'h0
`define RDF_DIS_SLOW 2'h1
`define RDF_DIS_MEDIUM 2'h2
`define RDF_DIS_FAST 2'h3

// axi response codes
`define RDF_RESP_OKAY 2'h0
`define RDF_RESP_SLVERR 2'h2

`endif

// *** design/rdf_regs.v ***
// rdf_regs.v: discharge-control and latched undervoltage fault registers behind AXI4-Lite
// assumes: fault inputs synchronous to i_clk; one write and one read outstanding at most
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rdf_consts.vh"

module rdf_regs (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // axi4-lite write address
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_awaddr,
    // axi4-lite write data
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    // axi4-lite write response
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    output reg [1:0] o_s_axi_bresp,
    // axi4-lite read address
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    input wire [31:0] i_s_axi_araddr,
    // axi4-lite read data
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    // undervoltage fault levels from the converters
    input wire i_stepdown5_undervolt,
    input wire i_stepdown6_undervolt,
    // regulator controls
    output reg o_regulator3_passthrough,
    output wire [2:0] o_regulator1_strength,
    output wire [2:0] o_regulator2_strength,
    output wire [2:0] o_regulator3_strength,
    // interrupt
    output reg o_irq
);

    reg [7:0] discharge_ctrl;
    reg [7:0] fault_status;
    reg [7:0] irq_mask;
    reg aw_held;
    reg w_held;
    reg [`RDF_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [7:0] next_fault_status;
    reg [7:0] fault_clear;
    reg [7:0] fault_set;
    wire do_write;
    wire [`RDF_ADDR_W-1:0] rd_addr;

    // maps a byte address to a known register; used by both read and write paths
    function is_mapped;
        input [`RDF_ADDR_W-1:0] addr;
        begin
            if (addr == `RDF_OFF_DISCHARGE) begin
                is_mapped = 1'b1;
            end else if (addr == `RDF_OFF_FAULT) begin
                is_mapped = 1'b1;
            end else if (addr == `RDF_OFF_IRQ_MASK) begin
                is_mapped = 1'b1;
            end else if (addr == `RDF_OFF_LIVE) begin
                is_mapped = 1'b1;
            end else begin
                is_mapped = 1'b0;
            end
        end
    endfunction

    // upper address bits must be zero to hit the bank
    function addr_in_range;
        input [31:0] addr;
        begin
            addr_in_range = (addr[31:`RDF_ADDR_W] == 28'h0000000);
        end
    endfunction

    reg aw_in_range;
    assign rd_addr = i_s_axi_araddr[`RDF_ADDR_W-1:0];
    assign do_write = aw_held && w_held && !o_s_axi_bvalid;

    // write address and data are taken independently, in either order
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            aw_in_range <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
        end else begin
            if (o_s_axi_awready && i_s_axi_awvalid) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr[`RDF_ADDR_W-1:0];
                aw_in_range <= addr_in_range(i_s_axi_awaddr);
                o_s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
                o_s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            // ready returns once the response is accepted
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end

    // write response
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `RDF_RESP_OKAY;
        end else if (do_write) begin
            o_s_axi_bvalid <= 1'b1;
            if (aw_in_range && is_mapped(aw_addr)) begin
                o_s_axi_bresp <= `RDF_RESP_OKAY;
            end else begin
                o_s_axi_bresp <= `RDF_RESP_SLVERR;
            end
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    wire wr_lane0;
    assign wr_lane0 = do_write && aw_in_range && w_strb[0];

    // discharge control and interrupt mask; only byte lane 0 carries data
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            discharge_ctrl <= `RDF_DIS_RESET;
            irq_mask <= `RDF_MASK_RESET;
        end else if (wr_lane0) begin
            if (aw_addr == `RDF_OFF_DISCHARGE) begin
                discharge_ctrl <= w_data[7:0] & `RDF_DIS_MASK;
            end else if (aw_addr == `RDF_OFF_IRQ_MASK) begin
                irq_mask <= w_data[7:0];
            end
        end
    end

    // latched faults: a fault in the clearing cycle keeps its flag set
    always @* begin
        fault_set = 8'h00;
        fault_set[`RDF_FLT_SD5_BIT] = i_stepdown5_undervolt;
        fault_set[`RDF_FLT_SD6_BIT] = i_stepdown6_undervolt;
        fault_clear = 8'h00;
        if (wr_lane0 && aw_addr == `RDF_OFF_FAULT) begin
            fault_clear = w_data[7:0];
        end
        next_fault_status = (fault_status & ~fault_clear) | fault_set;
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_status <= `RDF_FLT_RESET;
        end else begin
            fault_status <= next_fault_status;
        end
    end

    // level interrupt from unmasked latched flags
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_fault_status & irq_mask);
        end
    end

    // read channel: one read at a time, data answered the cycle after arvalid is taken
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `RDF_RESP_OKAY;
        end else if (o_s_axi_arready && i_s_axi_arvalid) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp <= `RDF_RESP_OKAY;
            o_s_axi_rdata <= 32'h00000000;
            if (!addr_in_range(i_s_axi_araddr) || !is_mapped(rd_addr)) begin
                o_s_axi_rresp <= `RDF_RESP_SLVERR;
            end else if (rd_addr == `RDF_OFF_DISCHARGE) begin
                o_s_axi_rdata <= {24'h000000, discharge_ctrl};
            end else if (rd_addr == `RDF_OFF_FAULT) begin
                o_s_axi_rdata <= {24'h000000, fault_status};
            end else if (rd_addr == `RDF_OFF_IRQ_MASK) begin
                o_s_axi_rdata <= {24'h000000, irq_mask};
            end else begin
                // live (unlatched) fault levels, for diagnosis
                o_s_axi_rdata <= {24'h000000, fault_set};
            end
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_regulator3_passthrough <= 1'b0;
        end else begin
            o_regulator3_passthrough <= discharge_ctrl[`RDF_DIS_PASS_BIT];
        end
    end

    // the three strength decoders are identical
    wire [5:0] level_bus;
    wire [8:0] strength_bus;
    assign level_bus = discharge_ctrl[5:0];
    assign o_regulator1_strength = strength_bus[2:0];
    assign o_regulator2_strength = strength_bus[5:3];
    assign o_regulator3_strength = strength_bus[8:6];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_dec
            rdf_strength_decode u_dec (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_level(level_bus[2*gi+1:2*gi]),
                .o_strength(strength_bus[3*gi+2:3*gi])
            );
        end
    endgenerate

endmodule // rdf_regs

`default_nettype wire

// *** design/rdf_strength_decode.v ***
// rdf_strength_decode.v: turns a 2-bit discharge field into one-hot strength enables
// assumes: field is stable from a register; output registered in the clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rdf_consts.vh"

module rdf_strength_decode (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // field
    input wire [1:0] i_level,
    // one-hot strength enables: bit0 slow, bit1 medium, bit2 fast
    output reg [2:0] o_strength
);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_strength <= 3'h0;
        end else begin
            case (i_level)
                `RDF_DIS_SLOW: o_strength <= 3'h1;
                `RDF_DIS_MEDIUM: o_strength <= 3'h2;
                `RDF_DIS_FAST: o_strength <= 3'h4;
                default: o_strength <= 3'h0;
            endcase
        end
    end

endmodule // rdf_strength_decode

`default_nettype wire

// *** verification/rdf_regs_properties.sv ***
// rdf_regs_properties.sv: port-level checks for the discharge and fault register bank
// assumes: bound onto rdf_regs; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module rdf_regs_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bus handshakes
    input wire logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready, o_s_axi_bvalid,
    input wire logic i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid,
    // faults and controls
    input wire logic i_stepdown5_undervolt, i_stepdown6_undervolt, o_regulator3_passthrough, o_irq,
    input wire logic [2:0] o_regulator1_strength, o_regulator2_strength, o_regulator3_strength
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_take;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !o_s_axi_bvalid ##1 o_s_axi_bvalid;
    endsequence
    a_r1_onehot: assert property ($onehot0(o_regulator1_strength)) else $error("r1 level");
    a_r2_onehot: assert property ($onehot0(o_regulator2_strength)) else $error("r2 level");
    a_r3_onehot: assert property ($onehot0(o_regulator3_strength)) else $error("r3 level");
    a_write_answer: assert property (s_wr_take |=> s_wr_answer) else $error("b late");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("r late");
    // regulator 3 passthrough and strength may only move as a consequence of a landed write
    a_pass_cause: assert property ($changed(o_regulator3_passthrough) |-> $past(o_s_axi_bvalid))
        else $error("pass moved");
    a_level_cause: assert property ($changed(o_regulator3_strength) |-> $past(o_s_axi_bvalid))
        else $error("level moved");
    a_irq_rise: assert property ($rose(o_irq) |-> $past(i_stepdown5_undervolt || i_stepdown6_undervolt)
        || !$past(o_s_axi_wready)) else $error("irq rose");
    a_irq_fall: assert property ($fell(o_irq) |-> !$past(o_s_axi_wready)) else $error("irq fell");
endmodule // rdf_regs_properties
bind rdf_regs rdf_regs_properties rdf_regs_properties_i (.i_clk, .i_rst_n, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rvalid, .i_stepdown5_undervolt, .i_stepdown6_undervolt,
    .o_regulator3_passthrough, .o_irq, .o_regulator1_strength, .o_regulator2_strength,
    .o_regulator3_strength);
`default_nettype wire

// *** verification/rdf_regs_test.sv ***
// rdf_regs_test.sv: register-level test of rdf_regs over AXI4-Lite
// assumes: rdf_consts.vh on the include path; checker bound separately
`timescale 1ns/1ps
`default_nettype none
`include "rdf_consts.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("FAIL %0t %h!=%h", $time, a, b); end end
module rdf_regs_test;
    logic i_clk, rst_n, awv, awr, wv, wrd, bv, brdy, arv, arr, rv, rrdy, f5, f6, pass, irq;
    logic [31:0] awa, wd, ara, rd;
    logic [3:0] ws;
    logic [1:0] br, rr, c1, c2, c3;
    logic [2:0] s1, s2, s3;
    logic [6:0] last;
    int miscompares = 0;
    int checks_done = 0;
    rdf_regs rdf_regs_i (.i_clk(i_clk), .i_rst_n(rst_n), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(brdy), .o_s_axi_bresp(br),
        .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv),
        .i_s_axi_rready(rrdy), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .i_stepdown5_undervolt(f5),
        .i_stepdown6_undervolt(f6), .o_regulator3_passthrough(pass), .o_regulator1_strength(s1),
        .o_regulator2_strength(s2), .o_regulator3_strength(s3), .o_irq(irq));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        $display("FAIL %0t no bus answer", $time);
        tally_and_finish();
    endtask
    // each valid drops once taken; bready held until bvalid
    task automatic axw(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        int n;
        n = 0;
        @(posedge i_clk);
        awa <= a;
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge i_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            n++;
        end while (!bv && n < 50);
        if (!bv) hang();
        brdy <= 1'b0;
        `CHK(br, er)
    endtask
    task automatic axr(input [31:0] a, input [31:0] ed, input [1:0] er);
        int n;
        n = 0;
        @(posedge i_clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge i_clk);
            if (arr) arv <= 1'b0;
            n++;
        end while (!rv && n < 50);
        if (!rv) hang();
        rrdy <= 1'b0;
        `CHK(rd, ed)
        `CHK(rr, er)
    endtask
    task automatic pulse(input [1:0] m);
        @(posedge i_clk);
        {f6, f5} <= m;
        @(posedge i_clk);
        {f6, f5} <= 2'b00;
        @(negedge i_clk);
    endtask
    function automatic [2:0] lvl(input [1:0] c);
        lvl = (c == 2'b00) ? 3'b000 : 3'b001 << (c - 2'b01);
    endfunction
    initial begin
        {rst_n, awv, wv, brdy, arv, rrdy, f5, f6} = 8'h00;
        {awa, wd, ara} = 96'h0;
        ws = 4'h0;
        repeat (16) @(posedge i_clk);
        rst_n <= 1'b1;
        axr(`RDF_OFF_DISCHARGE, 32'h0, `RDF_RESP_OKAY);
        axr(`RDF_OFF_FAULT, 32'h0, `RDF_RESP_OKAY);
        axr(`RDF_OFF_IRQ_MASK, 32'h0, `RDF_RESP_OKAY);
        // distinct code per field so swapped fields show up
        for (int c = 0; c < 4; c++) begin
            c3 = c[1:0];
            c2 = c3 + 2'b01;
            c1 = c3 + 2'b10;
            last = {c3[0], c3, c2, c1};
            axw(`RDF_OFF_DISCHARGE, {24'h0, 1'b1, last}, 4'hf, `RDF_RESP_OKAY);
            repeat (2) @(posedge i_clk);
            @(negedge i_clk);
            `CHK(s3, lvl(c3))
            `CHK(s2, lvl(c2))
            `CHK(s1, lvl(c1))
            `CHK(pass, c3[0])
            axr(`RDF_OFF_DISCHARGE, {25'h0, last}, `RDF_RESP_OKAY);
        end
        axw(`RDF_OFF_DISCHARGE, 32'h0, 4'h0, `RDF_RESP_OKAY);
        axw(32'h10, 32'hff, 4'hf, `RDF_RESP_SLVERR);
        axr(32'h10, 32'h0, `RDF_RESP_SLVERR);
        axr(`RDF_OFF_DISCHARGE, {25'h0, last}, `RDF_RESP_OKAY);
        pulse(2'b10);
        axr(`RDF_OFF_FAULT, 32'h20, `RDF_RESP_OKAY);
        pulse(2'b01);
        axr(`RDF_OFF_FAULT, 32'h30, `RDF_RESP_OKAY);
        axw(`RDF_OFF_FAULT, 32'h10, 4'hf, `RDF_RESP_OKAY);
        axr(`RDF_OFF_FAULT, 32'h20, `RDF_RESP_OKAY);
        axw(`RDF_OFF_IRQ_MASK, 32'h20, 4'hf, `RDF_RESP_OKAY);
        @(negedge i_clk);
        `CHK(irq, 1'b1)
        axw(`RDF_OFF_IRQ_MASK, 32'h0, 4'hf, `RDF_RESP_OKAY);
        @(negedge i_clk);
        `CHK(irq, 1'b0)
        axw(`RDF_OFF_IRQ_MASK, 32'h20, 4'hf, `RDF_RESP_OKAY);
        axw(`RDF_OFF_FAULT, 32'h20, 4'hf, `RDF_RESP_OKAY);
        @(negedge i_clk);
        `CHK(irq, 1'b0)
        axr(`RDF_OFF_FAULT, 32'h0, `RDF_RESP_OKAY);
        pulse(2'b10);
        `CHK(irq, 1'b1)
        // live levels follow a held fault with no latching
        f5 <= 1'b1;
        axr(`RDF_OFF_LIVE, 32'h10, `RDF_RESP_OKAY);
        f5 <= 1'b0;
        tally_and_finish();
    end
endmodule // rdf_regs_test
`default_nettype wire
